// file: rtl/lec_defines.vh
`ifndef LEC_DEFINES_VH
`define LEC_DEFINES_VH

// Register offsets (byte addresses in the switch register space)
`define LEC_ADDR_W          12
`define LEC_OFF_CTRL2       12'h312
`define LEC_OFF_AGE         12'h313
`define LEC_OFF_EVT_STAT    12'h314
`define LEC_OFF_EVT_MASK    12'h315

// Control two fields
`define LEC_CTRL2_RSVD      7
`define LEC_CTRL2_TRAP      6
`define LEC_CTRL2_DYN_FILT  5
`define LEC_CTRL2_STA_FILT  4
`define LEC_CTRL2_FLUSH_HI  3
`define LEC_CTRL2_FLUSH_LO  2
`define LEC_CTRL2_PRI_HI    1
`define LEC_CTRL2_PRI_LO    0
`define LEC_CTRL2_RST       8'h00

// Flush selection codes
`define LEC_FLUSH_NONE      2'h0
`define LEC_FLUSH_DYN       2'h1
`define LEC_FLUSH_STA       2'h2
`define LEC_FLUSH_BOTH      2'h3

// Priority select codes
`define LEC_PRI_DA          2'h0
`define LEC_PRI_SA          2'h1
`define LEC_PRI_HIGH        2'h2
`define LEC_PRI_LOW         2'h3

// Aging
`define LEC_AGE_RST         8'h4b

// Event bits
`define LEC_EVT_LEARN_FAIL  2
`define LEC_EVT_ALMOST_FULL 1
`define LEC_EVT_WRITE_FAIL  0
`define LEC_EVT_MASK_RST    3'h7

`endif

// file: rtl/lec_regs.v
// How it works
// - Double tagging plus trap bit: reserved multicast goes to host port only.
// - Dynamic hit with dynamic filtering on: entry map AND VLAN map, else entry map.
// - Static hit with static filtering on: entry map AND VLAN map, else entry map.
// - Flush selection 01 dynamic only, 10 static only, 11 both kinds.
// - Flush selection 00 means no flush; field returns to 00 when flush completes.
// - Priority select 00 takes destination lookup priority, 01 source lookup priority.
// - Priority select 10 takes higher of both priorities, 11 the lower.
// - Aging time is age period seconds times entry age count; period resets 0x4b.
// - Learn-failure status sets when a bucket holds only static entries.
// - Almost-full status sets when static write hits bucket with two or three entries.
// - Write-failure status sets when static write is rejected by a full bucket.
// - Summary interrupt is the OR of the three event status bits.
// - Mask bit one keeps its event out of the masked interrupt, zero lets it in; masks reset to one.
// - Self-clearing flush trigger removes only the selected kinds, then finishes.
`timescale 1ns/1ps
`default_nettype none
`include "lec_defines.vh"

module lec_regs #(
  parameter PORTS = 7,
  parameter PRI_W = 3
) (
  // Clock and reset
  input  wire                   clk,
  input  wire                   rst_b,
  // Register port
  input  wire [`LEC_ADDR_W-1:0] reg_addr,
  input  wire [7:0]             reg_wdata,
  input  wire                   reg_wr,
  input  wire                   reg_rd,
  output reg  [7:0]             reg_rdata,
  // Lookup engine events
  input  wire                   learn_fail_evt,
  input  wire                   static_wr_evt,
  input  wire [2:0]             static_wr_bucket_cnt,
  input  wire                   static_wr_reject_evt,
  // Forwarding decision
  input  wire                   lookup_hit,
  input  wire                   lookup_hit_static,
  input  wire [PORTS-1:0]       entry_port_map,
  input  wire [PORTS-1:0]       vlan_port_map,
  input  wire [PORTS-1:0]       host_port_map,
  input  wire                   double_tag_mode,
  input  wire                   reserved_mcast,
  output reg  [PORTS-1:0]       fwd_port_map,
  // Priority decision
  input  wire [PRI_W-1:0]       da_priority,
  input  wire [PRI_W-1:0]       sa_priority,
  output reg  [PRI_W-1:0]       mac_address_priority,
  // Flush handshake with table walker
  input  wire                   flush_trigger,
  input  wire                   flush_done,
  output reg                    flush_active,
  output reg                    flush_dynamic,
  output reg                    flush_static,
  // Aging
  input  wire [2:0]             entry_age_count,
  output reg  [10:0]            aging_time_sec,
  output reg  [7:0]             age_period,
  // Status
  output reg  [2:0]             event_status,
  output reg  [2:0]             event_mask,
  output reg                    lookup_summary_interrupt,
  output reg                    lookup_masked_interrupt
);

  reg        rst_sync1_q;
  reg        rst_sync2_q;
  wire       rst_n_int;
  reg  [7:0] ctrl2_q;
  reg  [7:0] ctrl2_d;
  reg  [7:0] age_q;
  reg  [2:0] stat_q;
  wire [2:0] stat_d;
  reg  [2:0] mask_q;
  reg  [1:0] flush_sel_run_q;
  reg  [1:0] flush_sel_run_d;
  reg        flush_run_q;
  reg        flush_run_d;
  reg  [7:0] rdata_d;
  reg  [PORTS-1:0] fwd_d;
  reg  [PRI_W-1:0] pri_d;
  wire [PRI_W-1:0] pri_higher;
  wire [PRI_W-1:0] pri_lower;
  wire [10:0] aging_prod;
  wire [2:0] evt_set;
  wire [2:0] evt_clr;
  wire       wr_ctrl2;
  wire       wr_age;
  wire       wr_stat;
  wire       wr_mask;
  wire [1:0] pri_sel;
  wire [1:0] flush_sel;
  wire       flush_start;
  wire       flush_end;

  // Reset release through two stages
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rst_sync1_q <= 1'b0;
      rst_sync2_q <= 1'b0;
    end else begin
      rst_sync1_q <= 1'b1;
      rst_sync2_q <= rst_sync1_q;
    end
  end
  assign rst_n_int = rst_sync2_q;

  assign wr_ctrl2    = reg_wr && (reg_addr == `LEC_OFF_CTRL2);
  assign wr_age      = reg_wr && (reg_addr == `LEC_OFF_AGE);
  assign wr_stat     = reg_wr && (reg_addr == `LEC_OFF_EVT_STAT);
  assign wr_mask     = reg_wr && (reg_addr == `LEC_OFF_EVT_MASK);
  assign pri_sel     = ctrl2_q[`LEC_CTRL2_PRI_HI:`LEC_CTRL2_PRI_LO];
  assign flush_sel   = ctrl2_q[`LEC_CTRL2_FLUSH_HI:`LEC_CTRL2_FLUSH_LO];
  // Selection 00 leaves the trigger without effect
  assign flush_start = flush_trigger && !flush_run_q && (flush_sel != `LEC_FLUSH_NONE);
  assign flush_end   = flush_run_q && flush_done;

  // Event sources per status bit
  assign evt_set[`LEC_EVT_LEARN_FAIL]  = learn_fail_evt;
  assign evt_set[`LEC_EVT_ALMOST_FULL] = static_wr_evt &&
    ((static_wr_bucket_cnt == 3'h2) || (static_wr_bucket_cnt == 3'h3));
  assign evt_set[`LEC_EVT_WRITE_FAIL]  = static_wr_reject_evt;
  assign evt_clr = wr_stat ? reg_wdata[2:0] : 3'h0;

  // Per-bit next value: set wins over a write-one clear
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi = gi + 1) begin : g_evt
      assign stat_d[gi] = evt_set[gi] | (stat_q[gi] & ~evt_clr[gi]);
    end
  endgenerate

  // Event status bits
  always @(posedge clk or negedge rst_n_int) begin
    if (!rst_n_int) begin
      stat_q <= 3'h0;
    end else begin
      stat_q <= stat_d;
    end
  end

  // Aging period register
  always @(posedge clk or negedge rst_n_int) begin
    if (!rst_n_int) begin
      age_q <= `LEC_AGE_RST;
    end else if (wr_age) begin
      age_q <= reg_wdata;
    end
  end

  // Event mask register
  always @(posedge clk or negedge rst_n_int) begin
    if (!rst_n_int) begin
      mask_q <= `LEC_EVT_MASK_RST;
    end else if (wr_mask) begin
      mask_q <= reg_wdata[2:0];
    end
  end

  // Flush sequencing, selection latched at start
  always @* begin
    flush_run_d     = flush_run_q;
    flush_sel_run_d = flush_sel_run_q;
    if (flush_start) begin
      flush_run_d     = 1'b1;
      flush_sel_run_d = flush_sel;
    end else if (flush_end) begin
      flush_run_d     = 1'b0;
      flush_sel_run_d = `LEC_FLUSH_NONE;
    end
  end

  always @(posedge clk or negedge rst_n_int) begin
    if (!rst_n_int) begin
      flush_run_q     <= 1'b0;
      flush_sel_run_q <= `LEC_FLUSH_NONE;
    end else begin
      flush_run_q     <= flush_run_d;
      flush_sel_run_q <= flush_sel_run_d;
    end
  end

  // Control two: completion clear beats a software write
  always @* begin
    ctrl2_d = ctrl2_q;
    if (flush_end) begin
      ctrl2_d = {ctrl2_q[7:4], `LEC_FLUSH_NONE, ctrl2_q[1:0]};
    end else if (wr_ctrl2) begin
      ctrl2_d = reg_wdata;
    end
  end

  always @(posedge clk or negedge rst_n_int) begin
    if (!rst_n_int) begin
      ctrl2_q <= `LEC_CTRL2_RST;
    end else begin
      ctrl2_q <= ctrl2_d;
    end
  end

  // Forwarding port map
  always @* begin
    fwd_d = {PORTS{1'b0}};
    if (double_tag_mode && ctrl2_q[`LEC_CTRL2_TRAP] && reserved_mcast) begin
      fwd_d = host_port_map;
    end else if (lookup_hit) begin
      fwd_d = entry_port_map;
      if (lookup_hit_static && ctrl2_q[`LEC_CTRL2_STA_FILT]) begin
        fwd_d = entry_port_map & vlan_port_map;
      end else if (!lookup_hit_static && ctrl2_q[`LEC_CTRL2_DYN_FILT]) begin
        fwd_d = entry_port_map & vlan_port_map;
      end
    end
  end

  // Priority selection
  assign pri_higher = (da_priority > sa_priority) ? da_priority : sa_priority;
  assign pri_lower  = (da_priority < sa_priority) ? da_priority : sa_priority;

  always @* begin
    case (pri_sel)
      `LEC_PRI_DA:   pri_d = da_priority;
      `LEC_PRI_SA:   pri_d = sa_priority;
      `LEC_PRI_HIGH: pri_d = pri_higher;
      `LEC_PRI_LOW:  pri_d = pri_lower;
      default:       pri_d = da_priority;
    endcase
  end

  // Aging product, widened before the multiply
  assign aging_prod = {3'h0, age_q} * {8'h00, entry_age_count};

  // Read mux
  always @* begin
    case (reg_addr)
      `LEC_OFF_CTRL2:    rdata_d = ctrl2_q;
      `LEC_OFF_AGE:      rdata_d = age_q;
      `LEC_OFF_EVT_STAT: rdata_d = {5'h00, stat_q};
      `LEC_OFF_EVT_MASK: rdata_d = {5'h00, mask_q};
      default:           rdata_d = 8'h00;
    endcase
  end

  // Read data, zero outside a read
  always @(posedge clk or negedge rst_n_int) begin
    if (!rst_n_int) begin
      reg_rdata <= 8'h00;
    end else begin
      reg_rdata <= reg_rd ? rdata_d : 8'h00;
    end
  end

  // Forwarding and priority outputs
  always @(posedge clk or negedge rst_n_int) begin
    if (!rst_n_int) begin
      fwd_port_map         <= {PORTS{1'b0}};
      mac_address_priority <= {PRI_W{1'b0}};
    end else begin
      fwd_port_map         <= fwd_d;
      mac_address_priority <= pri_d;
    end
  end

  // Flush outputs
  always @(posedge clk or negedge rst_n_int) begin
    if (!rst_n_int) begin
      flush_active  <= 1'b0;
      flush_dynamic <= 1'b0;
      flush_static  <= 1'b0;
    end else begin
      flush_active  <= flush_run_q;
      flush_dynamic <= flush_run_q && flush_sel_run_q[0];
      flush_static  <= flush_run_q && flush_sel_run_q[1];
    end
  end

  // Aging outputs
  always @(posedge clk or negedge rst_n_int) begin
    if (!rst_n_int) begin
      aging_time_sec <= 11'h000;
      age_period     <= `LEC_AGE_RST;
    end else begin
      aging_time_sec <= aging_prod;
      age_period     <= age_q;
    end
  end

  // Status outputs
  always @(posedge clk or negedge rst_n_int) begin
    if (!rst_n_int) begin
      event_status             <= 3'h0;
      event_mask               <= `LEC_EVT_MASK_RST;
      lookup_summary_interrupt <= 1'b0;
      lookup_masked_interrupt  <= 1'b0;
    end else begin
      event_status             <= stat_q;
      event_mask               <= mask_q;
      lookup_summary_interrupt <= |stat_q;
      lookup_masked_interrupt  <= |(stat_q & ~mask_q);
    end
  end

endmodule
`default_nettype wire

// file: dv/lec_regs_checker.sv
`timescale 1ns/1ps
`default_nettype none
`include "lec_defines.vh"

module lec_regs_checker #(
  parameter PORTS = 7,
  parameter PRI_W = 3
) (
  input wire logic                   clk,
  input wire logic                   rst_b,
  input wire logic [`LEC_ADDR_W-1:0] reg_addr,
  input wire logic                   reg_rd,
  input wire logic [7:0]             reg_rdata,
  input wire logic                   lookup_hit,
  input wire logic                   double_tag_mode,
  input wire logic [PORTS-1:0]       entry_port_map,
  input wire logic [PORTS-1:0]       host_port_map,
  input wire logic [PORTS-1:0]       fwd_port_map,
  input wire logic [PRI_W-1:0]       da_priority,
  input wire logic [PRI_W-1:0]       sa_priority,
  input wire logic [PRI_W-1:0]       mac_address_priority,
  input wire logic                   flush_trigger,
  input wire logic                   flush_done,
  input wire logic                   flush_active,
  input wire logic                   flush_dynamic,
  input wire logic                   flush_static,
  input wire logic [2:0]             entry_age_count,
  input wire logic [10:0]            aging_time_sec,
  input wire logic [7:0]             age_period,
  input wire logic [2:0]             event_status,
  input wire logic [2:0]             event_mask,
  input wire logic                   lookup_summary_interrupt,
  input wire logic                   lookup_masked_interrupt
);
  logic rst_s1_q;
  logic rst_s2_q;
  logic rst_s3_q;

  // Design leaves reset two edges after release; one more to settle outputs
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rst_s1_q <= 1'b0;
      rst_s2_q <= 1'b0;
      rst_s3_q <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_s2_q <= rst_s1_q;
      rst_s3_q <= rst_s2_q;
    end
  end

  default clocking @(posedge clk); endclocking
  default disable iff (!rst_s3_q);

  a_summary_or: assert property (lookup_summary_interrupt == |event_status)
    else $error("summary interrupt mismatch");
  a_masked_or: assert property (lookup_masked_interrupt == |(event_status & ~event_mask))
    else $error("masked interrupt mismatch");
  a_aging_product: assert property (aging_time_sec == age_period * $past(entry_age_count))
    else $error("aging time mismatch");
  a_pri_source: assert property (mac_address_priority == $past(da_priority) ||
    mac_address_priority == $past(sa_priority))
    else $error("priority not from a lookup");
  a_fwd_subset: assert property ((fwd_port_map & ~($past(entry_port_map) |
    $past(host_port_map))) == 0)
    else $error("forward map outside entry map");
  a_fwd_nohit: assert property (!$past(lookup_hit) && !$past(double_tag_mode)
    |-> fwd_port_map == 0)
    else $error("forward without hit");
  a_flush_kind: assert property (flush_active == (flush_dynamic || flush_static))
    else $error("flush kind mismatch");
  a_flush_start: assert property ($rose(flush_active) |-> $past(flush_trigger) ||
    $past(flush_trigger, 2) || $past(flush_trigger, 3))
    else $error("flush without trigger");
  a_flush_end: assert property ($fell(flush_active) |-> $past(flush_done) ||
    $past(flush_done, 2) || $past(flush_done, 3))
    else $error("flush ended without done");
  a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 0)
    else $error("read data outside read");
  a_rsvd_zero: assert property ($past(reg_rd) && ($past(reg_addr) == `LEC_OFF_EVT_STAT ||
    $past(reg_addr) == `LEC_OFF_EVT_MASK) |-> reg_rdata[7:3] == 0)
    else $error("reserved bits set");
endmodule

bind lec_regs lec_regs_checker #(.PORTS(PORTS), .PRI_W(PRI_W)) u_chk (.*);
`default_nettype wire

// file: dv/tb_lec_regs.sv
`timescale 1ns/1ps
`default_nettype none
`include "lec_defines.vh"
`define CHK(n, e, s) begin checks_done++; if ((s) !== (e)) begin miscompares++; \
  $display("wrong value %s exp %h got %h", n, e, s); end end

module tb_lec_regs;
  logic clk, rst_b, reg_wr, reg_rd, learn_fail_evt, static_wr_evt, static_wr_reject_evt;
  logic lookup_hit, lookup_hit_static, double_tag_mode, reserved_mcast, flush_trigger;
  logic flush_done, flush_active, flush_dynamic, flush_static;
  logic lookup_summary_interrupt, lookup_masked_interrupt;
  logic [11:0] reg_addr;
  logic [7:0]  reg_wdata, reg_rdata, age_period;
  logic [6:0]  entry_port_map, vlan_port_map, host_port_map, fwd_port_map;
  logic [2:0]  static_wr_bucket_cnt, da_priority, sa_priority, mac_address_priority;
  logic [2:0]  entry_age_count, event_status, event_mask;
  logic [10:0] aging_time_sec;
  int          miscompares, checks_done, i;
  // Control byte, hit/static/double-tag/reserved flags, forward map, priority
  logic [21:0] rows [8] = '{{8'h00, 4'h8, 7'h5a, 3'd2}, {8'h21, 4'h8, 7'h12, 3'd5},
    {8'h22, 4'hc, 7'h5a, 3'd5}, {8'h13, 4'hc, 7'h12, 3'd2}, {8'h10, 4'h8, 7'h5a, 3'd2},
    {8'h40, 4'h3, 7'h40, 3'd2}, {8'h80, 4'h3, 7'h00, 3'd2}, {8'h41, 4'hb, 7'h40, 3'd5}};

  lec_regs dut (.*);

  initial begin
    clk = 0;
    forever #12.5 clk = ~clk;
  end

  task automatic wr(input [11:0] a, input [7:0] d);
    @(posedge clk); reg_wr <= 1; reg_addr <= a; reg_wdata <= d;
    @(posedge clk); reg_wr <= 0;
  endtask
  task automatic rdchk(input [11:0] a, input [7:0] e);
    @(posedge clk); reg_rd <= 1; reg_addr <= a;
    @(posedge clk); reg_rd <= 0;
    #1 `CHK("rdata", e, reg_rdata)
  endtask
  task automatic ev(input lf, input sw, input rj, input [2:0] c);
    @(posedge clk); {learn_fail_evt, static_wr_evt, static_wr_reject_evt} <= {lf, sw, rj};
    static_wr_bucket_cnt <= c;
    @(posedge clk); {learn_fail_evt, static_wr_evt, static_wr_reject_evt} <= 3'h0;
  endtask
  task automatic pulse_flush(input t);
    @(posedge clk); flush_trigger <= t; flush_done <= !t;
    @(posedge clk); flush_trigger <= 0; flush_done <= 0;
    repeat (3) @(posedge clk);
    #1;
  endtask
  task automatic do_reset;
    rst_b <= 0;
    repeat (10) @(posedge clk);
    rst_b <= 1;
    repeat (4) @(posedge clk);
  endtask
  task automatic stop_test;
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge clk);
    miscompares++;
    stop_test;
  end

  initial begin
    {rst_b, reg_wr, reg_rd, reg_addr, reg_wdata, learn_fail_evt, static_wr_evt} = 0;
    {static_wr_reject_evt, static_wr_bucket_cnt, lookup_hit, lookup_hit_static} = 0;
    {double_tag_mode, reserved_mcast, flush_trigger, flush_done, entry_age_count} = 0;
    {entry_port_map, vlan_port_map, host_port_map} = {7'h5a, 7'h33, 7'h40};
    {da_priority, sa_priority} = {3'd2, 3'd5};
    do_reset;
    for (i = 0; i < 8; i++) begin
      wr(`LEC_OFF_CTRL2, rows[i][21:14]);
      {lookup_hit, lookup_hit_static, double_tag_mode, reserved_mcast} <= rows[i][13:10];
      repeat (3) @(posedge clk);
      #1 `CHK("fwd", rows[i][9:3], fwd_port_map)
      `CHK("pri", rows[i][2:0], mac_address_priority)
    end
    for (i = 1; i < 4; i++) begin
      wr(`LEC_OFF_CTRL2, {4'h0, i[1:0], 2'h0});
      pulse_flush(1);
      `CHK("flush", {2'b10, i[1:0]}, {flush_active, 1'b0, flush_static, flush_dynamic})
      pulse_flush(0);
      rdchk(`LEC_OFF_CTRL2, 8'h00);
    end
    pulse_flush(1);
    `CHK("idle", 1'b0, flush_active)
    wr(`LEC_OFF_EVT_MASK, 8'hfa);
    rdchk(`LEC_OFF_EVT_MASK, 8'h02);
    `CHK("evmask", 3'h2, event_mask)
    ev(1, 0, 0, 0);
    rdchk(`LEC_OFF_EVT_STAT, 8'h04);
    `CHK("sum", 2'b11, {lookup_summary_interrupt, lookup_masked_interrupt})
    ev(0, 1, 0, 1);
    rdchk(`LEC_OFF_EVT_STAT, 8'h04);
    ev(0, 1, 0, 3);
    rdchk(`LEC_OFF_EVT_STAT, 8'h06);
    ev(0, 0, 1, 0);
    rdchk(`LEC_OFF_EVT_STAT, 8'h07);
    wr(`LEC_OFF_EVT_STAT, 8'h00);
    rdchk(`LEC_OFF_EVT_STAT, 8'h07);
    wr(`LEC_OFF_EVT_STAT, 8'hfa);
    rdchk(`LEC_OFF_EVT_STAT, 8'h05);
    wr(`LEC_OFF_EVT_STAT, 8'h05);
    rdchk(`LEC_OFF_EVT_STAT, 8'h00);
    `CHK("sum", 1'b0, lookup_summary_interrupt)
    @(posedge clk);
    reg_wr         <= 1;
    reg_addr       <= `LEC_OFF_EVT_STAT;
    reg_wdata      <= 8'h04;
    learn_fail_evt <= 1;
    @(posedge clk);
    reg_wr         <= 0;
    learn_fail_evt <= 0;
    rdchk(`LEC_OFF_EVT_STAT, 8'h04);
    `CHK("evstat", 3'h4, event_status)
    wr(`LEC_OFF_EVT_STAT, 8'h04);
    rdchk(`LEC_OFF_EVT_STAT, 8'h00);
    wr(`LEC_OFF_AGE, 8'hff);
    entry_age_count <= 3'd7;
    rdchk(`LEC_OFF_AGE, 8'hff);
    @(posedge clk);
    #1 `CHK("aging", 11'd1785, aging_time_sec)
    `CHK("ageper", 8'hff, age_period)
    wr(12'h316, 8'h55);
    rdchk(12'h316, 8'h00);
    do_reset;
    rdchk(`LEC_OFF_CTRL2, 8'h00);
    rdchk(`LEC_OFF_AGE, 8'h4b);
    rdchk(`LEC_OFF_EVT_STAT, 8'h00);
    rdchk(`LEC_OFF_EVT_MASK, 8'h07);
    stop_test;
  end
endmodule
`default_nettype wire
